//--- cltx_pkg.sv
package cltx_pkg;

  localparam int unsigned CLTX_LANES     = 2;
  localparam int unsigned CLTX_BYTE_W    = 8;
  localparam int unsigned CLTX_WORD_B    = 4;
  localparam int unsigned CLTX_LANE_W    = CLTX_BYTE_W * CLTX_WORD_B;
  localparam int unsigned CLTX_POS_W     = 16;
  localparam int unsigned CLTX_DEF_F     = 8;
  localparam int unsigned CLTX_DEF_K     = 4;
  localparam int unsigned CLTX_BUF_DEPTH = 2;
  localparam int unsigned CLTX_SYNC_FF   = 2;

  localparam logic [1:0]  CLTX_IDX_LAST  = 2'h3;
  localparam logic [1:0]  CLTX_IDX_FIRST = 2'h0;
  localparam logic [1:0]  CLTX_CNT_ZERO  = 2'h0;
  localparam logic [1:0]  CLTX_CNT_ONE   = 2'h1;
  localparam logic [1:0]  CLTX_CNT_FULL  = 2'h2;
  localparam logic [CLTX_POS_W-1:0] CLTX_POS_ZERO = 16'h0000;

  typedef struct packed {
    logic [CLTX_LANES-1:0][CLTX_LANE_W-1:0] lane;
    logic [CLTX_WORD_B-1:0]                 fmark;
    logic [CLTX_WORD_B-1:0]                 mmark;
  } cltx_beat_t;

  typedef struct packed {
    logic [CLTX_LANES-1:0][CLTX_BYTE_W-1:0] lane;
    logic                                   frame_first;
    logic                                   mf_first;
  } cltx_octet_t;

endpackage

//--- cltx_user_port.sv
`timescale 1ns/1ps
`default_nettype none

module cltx_user_port
  import cltx_pkg::*;
#(
  parameter int unsigned OCTETS_PER_FRAME = CLTX_DEF_F,
  parameter int unsigned FRAMES_PER_MF    = CLTX_DEF_K
) (
  input  wire logic                                clock_in,
  input  wire logic                                rst_n_in,
  input  wire logic [CLTX_LANES*CLTX_LANE_W-1:0]   tx_data_in,
  input  wire logic                                sync_req_n_in,
  input  wire logic                                octet_ready_in,
  output logic                                     tx_ready_out,
  output logic                                     stream_rst_n_out,
  output logic [CLTX_WORD_B-1:0]                   frame_first_byte_marker_out,
  output logic [CLTX_WORD_B-1:0]                   multiframe_first_byte_marker_out,
  output logic [CLTX_LANES*CLTX_BYTE_W-1:0]        octet_data_out,
  output logic                                     octet_valid_out,
  output logic                                     octet_frame_first_out,
  output logic                                     octet_mf_first_out
);

  localparam int unsigned MF_OCTETS = OCTETS_PER_FRAME * FRAMES_PER_MF;
  localparam logic [CLTX_POS_W-1:0] F_LEN  = CLTX_POS_W'(OCTETS_PER_FRAME);
  localparam logic [CLTX_POS_W-1:0] MF_LEN = CLTX_POS_W'(MF_OCTETS);
  localparam logic [CLTX_POS_W-1:0] STEP   = CLTX_POS_W'(CLTX_WORD_B);

  // Sync request from the far converter, two flops before use
  logic [CLTX_SYNC_FF-1:0] sync_meta_q;
  logic                    link_up;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync_meta_q <= '0;
    end else begin
      sync_meta_q <= {sync_meta_q[0], sync_req_n_in};
    end
  end

  assign link_up = sync_meta_q[1];

  // Stream reset towards user logic
  logic stream_rst_n_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stream_rst_n_q <= 1'b0;
    end else begin
      stream_rst_n_q <= 1'b1;
    end
  end

  // Two-entry buffer
  cltx_beat_t       buf_q [CLTX_BUF_DEPTH];
  logic             wr_ptr_q;
  logic             rd_ptr_q;
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             ready_q;
  logic             ready_d;
  logic             push;
  logic             pop;
  cltx_beat_t       push_beat;

  // Octet serializer state
  cltx_beat_t       word_q;
  logic             busy_q;
  logic [1:0]       idx_q;
  logic             ser_last;
  logic             ser_free;
  logic             ser_step;
  logic             buf_empty;
  logic             buf_room;
  logic             link_ok;

  assign ser_step = busy_q && octet_ready_in;
  assign ser_last = ser_step && (idx_q == CLTX_IDX_LAST);
  assign ser_free = !busy_q || ser_last;
  // No valid on this port: every ready cycle carries a word
  assign push     = ready_q;
  // Refill the serializer in the cycle its last octet leaves
  assign pop      = !buf_empty && ser_free;

  assign cnt_d = (push && !pop) ? cnt_q + CLTX_CNT_ONE :
                 (pop && !push) ? cnt_q - CLTX_CNT_ONE : cnt_q;

  assign buf_empty = (cnt_q == CLTX_CNT_ZERO);
  assign buf_room  = (cnt_d < CLTX_CNT_FULL);
  assign link_ok   = link_up && stream_rst_n_q;

  // Ready only with link up and a free slot after this cycle
  assign ready_d = link_ok && buf_room;

  // Octet positions of byte 0 of the word now being offered
  logic [CLTX_POS_W-1:0] fpos_q;
  logic [CLTX_POS_W-1:0] mpos_q;
  logic [CLTX_POS_W-1:0] fpos_d;
  logic [CLTX_POS_W-1:0] mpos_d;
  logic [CLTX_POS_W-1:0] fpos_nx;
  logic [CLTX_POS_W-1:0] mpos_nx;
  logic [CLTX_WORD_B-1:0] fmark_d;
  logic [CLTX_WORD_B-1:0] mmark_d;
  logic [CLTX_WORD_B-1:0] fmark_q;
  logic [CLTX_WORD_B-1:0] mmark_q;
  logic [CLTX_POS_W-1:0] fpos_inc;
  logic [CLTX_POS_W-1:0] mpos_inc;
  logic [CLTX_POS_W-1:0] fpos_nx_inc;
  logic [CLTX_POS_W-1:0] mpos_nx_inc;

  assign fpos_inc    = CLTX_POS_W'((fpos_q + STEP) % F_LEN);
  assign mpos_inc    = CLTX_POS_W'((mpos_q + STEP) % MF_LEN);
  assign fpos_nx_inc = CLTX_POS_W'((fpos_d + STEP) % F_LEN);
  assign mpos_nx_inc = CLTX_POS_W'((mpos_d + STEP) % MF_LEN);

  // Sync loss restarts frame and multiframe at byte 0
  assign fpos_d  = !link_up ? CLTX_POS_ZERO :
                   push ? fpos_inc : fpos_q;
  assign mpos_d  = !link_up ? CLTX_POS_ZERO :
                   push ? mpos_inc : mpos_q;
  // Position of the word offered in the cycle after next
  assign fpos_nx = ready_d ? fpos_nx_inc : fpos_d;
  assign mpos_nx = ready_d ? mpos_nx_inc : mpos_d;

  // One marker bit per byte position, shared by all lanes
  genvar gi;
  generate
    for (gi = 0; gi < CLTX_WORD_B; gi++) begin : g_mark
      assign fmark_d[gi] = (CLTX_POS_W'((fpos_nx + CLTX_POS_W'(gi)) % F_LEN)
                            == CLTX_POS_ZERO);
      assign mmark_d[gi] = (CLTX_POS_W'((mpos_nx + CLTX_POS_W'(gi)) % MF_LEN)
                            == CLTX_POS_ZERO);
    end
  endgenerate

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fpos_q <= CLTX_POS_ZERO;
      mpos_q <= CLTX_POS_ZERO;
    end else begin
      fpos_q <= fpos_d;
      mpos_q <= mpos_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fmark_q <= '0;
    end else begin
      fmark_q <= fmark_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      mmark_q <= '0;
    end else begin
      mmark_q <= mmark_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  // Markers of the current word travel with it into the buffer
  logic [CLTX_WORD_B-1:0] cur_fmark_q;
  logic [CLTX_WORD_B-1:0] cur_mmark_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cur_fmark_q <= '0;
      cur_mmark_q <= '0;
    end else begin
      cur_fmark_q <= fmark_q;
      cur_mmark_q <= mmark_q;
    end
  end

  assign push_beat.lane  = tx_data_in;
  assign push_beat.fmark = cur_fmark_q;
  assign push_beat.mmark = cur_mmark_q;

  always_ff @(posedge clock_in) begin
    if (push) begin
      buf_q[wr_ptr_q] <= push_beat;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_ptr_q <= 1'b0;
    end else begin
      rd_ptr_q <= rd_ptr_q ^ pop;
    end
  end

  // Count never passes two: ready looks at the next count
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt_q <= CLTX_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Serializer: one octet per lane per accepted step
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
    end else if (pop) begin
      busy_q <= 1'b1;
    end else if (ser_last) begin
      busy_q <= 1'b0;
    end
  end

  // Byte index restarts with every loaded word
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      idx_q <= CLTX_IDX_FIRST;
    end else if (pop || ser_last) begin
      idx_q <= CLTX_IDX_FIRST;
    end else if (ser_step) begin
      idx_q <= idx_q + CLTX_CNT_ONE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      word_q <= '0;
    end else if (pop) begin
      word_q <= buf_q[rd_ptr_q];
    end
  end

  cltx_octet_t octet_d;
  cltx_octet_t octet_q;
  logic        octet_valid_q;

  generate
    for (gi = 0; gi < CLTX_LANES; gi++) begin : g_lane
      assign octet_d.lane[gi] = word_q.lane[gi][idx_q*CLTX_BYTE_W +: CLTX_BYTE_W];
    end
  endgenerate

  assign octet_d.frame_first = word_q.fmark[idx_q];
  assign octet_d.mf_first    = word_q.mmark[idx_q];

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      octet_valid_q <= 1'b0;
    end else begin
      octet_valid_q <= ser_step;
    end
  end

  // Octet and its flags stand until the next valid
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      octet_q <= '0;
    end else if (ser_step) begin
      octet_q <= octet_d;
    end
  end

  assign tx_ready_out                     = ready_q;
  assign stream_rst_n_out                 = stream_rst_n_q;
  assign frame_first_byte_marker_out      = fmark_q;
  assign multiframe_first_byte_marker_out = mmark_q;
  assign octet_data_out                   = octet_q.lane;
  assign octet_valid_out                  = octet_valid_q;
  assign octet_frame_first_out            = octet_q.frame_first;
  assign octet_mf_first_out               = octet_q.mf_first;

endmodule

`default_nettype wire

//--- cltx_user_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cltx_user_port_monitor
  import cltx_pkg::*;
(
  input wire logic                   clock_in,
  input wire logic                   rst_n_in,
  input wire logic                   sync_req_n_in,
  input wire logic                   octet_ready_in,
  input wire logic                   tx_ready_out,
  input wire logic                   stream_rst_n_out,
  input wire logic [CLTX_WORD_B-1:0] frame_first_byte_marker_out,
  input wire logic [CLTX_WORD_B-1:0] multiframe_first_byte_marker_out,
  input wire logic                   octet_valid_out,
  input wire logic                   octet_frame_first_out,
  input wire logic                   octet_mf_first_out
);
  default clocking @(posedge clock_in); endclocking
  sequence s_sync_lost; !sync_req_n_in [*3]; endsequence
  sequence s_stall; (!octet_ready_in && sync_req_n_in) [*8]; endsequence
  property p_rst_hold; !rst_n_in |=> !stream_rst_n_out && !tx_ready_out; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("output up in reset");
  property p_rst_rel; rst_n_in |=> stream_rst_n_out; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("stream reset stuck");
  property p_rst_mark; !rst_n_in |=> frame_first_byte_marker_out == 4'h0 && multiframe_first_byte_marker_out == 4'h0; endproperty
  a_rst_mark: assert property (p_rst_mark) else $error("marker in reset");
  property p_rdy_sync; disable iff (!rst_n_in) s_sync_lost |=> !tx_ready_out; endproperty
  a_rdy_sync: assert property (p_rdy_sync) else $error("ready without sync");
  property p_rdy_full; disable iff (!rst_n_in) s_stall |=> ##[0:3] !tx_ready_out; endproperty
  a_rdy_full: assert property (p_rdy_full) else $error("ready while full");
  property p_mf_sub;
    disable iff (!rst_n_in) (multiframe_first_byte_marker_out & ~frame_first_byte_marker_out) == 4'h0;
  endproperty
  a_mf_sub: assert property (p_mf_sub) else $error("multiframe mark off frame");
  property p_oct_mf; disable iff (!rst_n_in) octet_valid_out && octet_mf_first_out |-> octet_frame_first_out; endproperty
  a_oct_mf: assert property (p_oct_mf) else $error("multiframe octet flag");
  property p_oct_stall; disable iff (!rst_n_in) !octet_ready_in |=> !octet_valid_out; endproperty
  a_oct_stall: assert property (p_oct_stall) else $error("octet during stall");
endmodule
bind cltx_user_port cltx_user_port_monitor u_mon (.clock_in, .rst_n_in, .sync_req_n_in, .octet_ready_in,
  .tx_ready_out, .stream_rst_n_out, .frame_first_byte_marker_out, .multiframe_first_byte_marker_out,
  .octet_valid_out, .octet_frame_first_out, .octet_mf_first_out);
`default_nettype wire

//--- cltx_user_src.sv
`timescale 1ns/1ps
`default_nettype none
module cltx_user_src (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        aligned_in,
  input  wire logic        tx_ready_in,
  output logic             sync_req_n_out,
  output logic [63:0]      tx_data_out
);
  logic [7:0] word_q = 8'h00;
  logic       took_q = 1'b0;
  initial sync_req_n_out = 1'b0;
  always @(posedge clock_in) took_q <= rst_n_in && tx_ready_in === 1'b1;
  always @(negedge clock_in) begin
    sync_req_n_out <= aligned_in;
    if (!rst_n_in) word_q <= 8'h00;
    else if (took_q) word_q <= word_q + 8'h01;
  end
  for (genvar i = 0; i < 8; i++) begin : g_b
    assign tx_data_out[8*i +: 8] = {word_q[4:0], 3'(i)};
  end
endmodule
`default_nettype wire

//--- cltx_user_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cltx_user_port_bench;
  import cltx_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        aligned = 1'b0;
  logic        octet_ready_in = 1'b1;
  logic        sync_n, rdy, srst_n, ov, off, omf;
  logic [63:0] data;
  logic [3:0]  fm, mm;
  logic [15:0] od;
  int          num_errors = 0, cmp_count = 0, n_oct = 0;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  always #10 clock_in = ~clock_in;
  cltx_user_port #(.OCTETS_PER_FRAME(2), .FRAMES_PER_MF(2)) u_dut (.clock_in, .rst_n_in, .tx_data_in(data),
    .sync_req_n_in(sync_n), .octet_ready_in, .tx_ready_out(rdy), .stream_rst_n_out(srst_n),
    .frame_first_byte_marker_out(fm), .multiframe_first_byte_marker_out(mm), .octet_data_out(od),
    .octet_valid_out(ov), .octet_frame_first_out(off), .octet_mf_first_out(omf));
  cltx_user_src u_src (.clock_in, .rst_n_in, .aligned_in(aligned), .tx_ready_in(rdy), .sync_req_n_out(sync_n),
    .tx_data_out(data));
  // Octet stream follows the source pattern
  always @(posedge clock_in) if (ov === 1'b1) begin
    `CHK(od, {n_oct[6:2], 1'b1, n_oct[1:0], n_oct[6:2], 1'b0, n_oct[1:0]})
    `CHK({off, omf}, {n_oct[0] == 0, n_oct[1:0] == 0})
    n_oct++;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset;
    repeat (2) @(negedge clock_in);
    `CHK({srst_n, rdy, fm, mm}, 10'h000)
    rst_n_in = 1'b1;
    repeat (6) @(negedge clock_in);
    `CHK({srst_n, rdy}, 2'h2)
    $display("reset test done");
  endtask
  task automatic t_stream;
    aligned = 1'b1;
    repeat (12) @(negedge clock_in);
    for (int i = 0; i < 8 && rdy !== 1'b1; i++) @(negedge clock_in);
    `CHK({rdy, fm, mm}, 9'h151)
    $display("stream test done");
  endtask
  task automatic t_stall;
    octet_ready_in = 1'b0;
    repeat (10) @(negedge clock_in);
    `CHK(rdy, 1'b0)
    octet_ready_in = 1'b1;
    repeat (40) @(negedge clock_in);
    `CHK(n_oct > 32, 1'b1)
    $display("stall test done");
  endtask
  initial begin
    #40000;
    num_errors++;
    print_verdict;
  end
  initial begin
    t_reset;
    t_stream;
    t_stall;
    print_verdict;
  end
endmodule
`default_nettype wire
